// *** src/frt_pkg.sv ***
package frt_pkg;

	// ----------------------------------------------------------------
	// register word indexes (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_CNT   = 6'h00;
	localparam logic [5:0] IDX_CLR   = 6'h01;
	localparam logic [5:0] IDX_TCS   = 6'h02;
	localparam logic [5:0] IDX_OCS   = 6'h03;
	localparam logic [5:0] IDX_ICS   = 6'h04;
	localparam logic [5:0] IDX_IST   = 6'h05;
	localparam logic [5:0] IDX_IMK   = 6'h06;
	localparam logic [5:0] IDX_OCP0  = 6'h08;
	localparam logic [5:0] IDX_CAP0  = 6'h0c;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TCS_SEL   = 0;
	localparam int TCS_MODE  = 3;
	localparam int TCS_CLRB  = 4;
	localparam int TCS_CMIE  = 5;
	localparam int OCS_FLAG  = 0;
	localparam int OCS_IE    = 4;
	localparam int OCS_LVL   = 8;
	localparam int OCS_PAIR  = 12;
	localparam int ICS_FLAG  = 0;
	localparam int ICS_IE    = 4;
	localparam int ICS_EDGE  = 8;
	localparam int IST_OVF   = 0;
	localparam int IST_CLRM  = 1;
	localparam int IST_CMP   = 2;
	localparam int IST_CAP   = 6;
	localparam int IST_W     = 10;

	// ----------------------------------------------------------------
	// reset values and bus answers
	// ----------------------------------------------------------------
	localparam logic [15:0] CNT_RST  = 16'h0000;
	localparam logic [15:0] CLR_RST  = 16'hffff;
	localparam logic [15:0] OCP_RST  = 16'h0000;
	localparam logic [31:0] REG_RST  = 32'h0000_0000;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;

endpackage

// *** src/frt_timer.sv ***
`timescale 1ns/1ps
// Contract
// - one 16-bit up counter, read and written by software, steps each tick
// - counter value is the shared time base for compare and capture
// - count tick selectable as clock divided by 1 through 128
// - counter wrap from ffff to zero raises an interrupt event
// - clear after compare-clear match raises interrupt if enabled and mode set
// - counter cleared at reset and on writing one to the clear bit
// - with clear mode set, counter clears when equal to compare-clear value
// - writing zero to the counter restarts counting from zero
// - compare equal to counter inverts the channel's output latch
// - four independent compare channels, each with own value and flag
// - a pair of compare channels may toggle one output pin
// - match sets the flag; interrupt only while channel enable is one
// - software presets each compare output level
// - valid capture edge copies the counter into the capture register
// - four independent capture channels, one input pin each
// - capture edge selectable as rising, falling or both
// - valid edge sets capture flag; interrupt when channel enable is one
module frt_timer #(
	parameter int NCH = 4
) (
	input  wire logic              clock_i,
	input  wire logic              reset_n_i,
	input  wire logic [7:0]        s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	input  wire logic [7:0]        s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	input  wire logic [NCH-1:0]    capture_input_pins_i,
	output logic [NCH-1:0]         compare_out_o,
	output logic                   irq_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	localparam int IST_W_L = frt_pkg::IST_W;
	logic [15:0]     cnt_r;
	logic [15:0]     clr_val_r;
	logic [6:0]      presc_r;
	logic [2:0]      sel_r;
	logic            mode_r;
	logic            cmie_r;
	logic            upd_r;
	logic [NCH-1:0]  mflag_r;
	logic [NCH-1:0]  mie_r;
	logic [NCH-1:0]  lvl_r;
	logic [1:0]      pair_r;
	logic [NCH-1:0]  cflag_r;
	logic [NCH-1:0]  cie_r;
	logic [2*NCH-1:0] edge_r;
	logic [IST_W_L-1:0] ist_r;
	logic [IST_W_L-1:0] imk_r;
	logic [15:0]     ocp_r [NCH];
	logic [15:0]     icp_r [NCH];
	logic [NCH-1:0]  sync1_r;
	logic [NCH-1:0]  sync2_r;
	logic [NCH-1:0]  sync3_r;
	logic            irq_r;

	// bus state
	logic            awrdy_r;
	logic            wrdy_r;
	logic            arrdy_r;
	logic            awfull_r;
	logic            wfull_r;
	logic [5:0]      awidx_r;
	logic [31:0]     wdat_r;
	logic [3:0]      wstb_r;
	logic            bvalid_r;
	logic [1:0]      bresp_r;
	logic            rvalid_r;
	logic [1:0]      rresp_r;
	logic [31:0]     rdata_r;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic mapped(input logic [5:0] idx);
		mapped = (idx <= frt_pkg::IDX_IMK) ||
			(idx >= frt_pkg::IDX_OCP0 &&
			idx < frt_pkg::IDX_CAP0 + 6'(NCH));
	endfunction

	function automatic logic [31:0] lanes(input logic [3:0] s);
		lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [31:0] m);
		merge = (old & ~m) | (d & m);
	endfunction

	// ----------------------------------------------------------------
	// write path
	// ----------------------------------------------------------------
	wire         aw_take = s_axi_awvalid_i & awrdy_r;
	wire         w_take  = s_axi_wvalid_i & wrdy_r;
	wire         do_wr   = awfull_r & wfull_r & ~bvalid_r;
	wire [31:0]  wm      = lanes(wstb_r);
	wire         wr_ok   = do_wr & mapped(awidx_r);
	wire         wr_cnt  = wr_ok & (awidx_r == frt_pkg::IDX_CNT);
	wire         wr_clr  = wr_ok & (awidx_r == frt_pkg::IDX_CLR);
	wire         wr_tcs  = wr_ok & (awidx_r == frt_pkg::IDX_TCS);
	wire         wr_ocs  = wr_ok & (awidx_r == frt_pkg::IDX_OCS);
	wire         wr_ics  = wr_ok & (awidx_r == frt_pkg::IDX_ICS);
	wire         wr_ist  = wr_ok & (awidx_r == frt_pkg::IDX_IST);
	wire         wr_imk  = wr_ok & (awidx_r == frt_pkg::IDX_IMK);
	wire [31:0]  cnt_m   = merge({16'h0000, cnt_r}, wdat_r, wm);
	wire [31:0]  tcs_cur = {26'h0, cmie_r, 1'b0, mode_r, sel_r};
	wire [31:0]  tcs_m   = merge(tcs_cur, wdat_r, wm);
	wire [31:0]  ocs_cur = {18'h0, pair_r, lvl_r, mie_r, mflag_r};
	wire [31:0]  ocs_m   = merge(ocs_cur, wdat_r, wm);
	wire [31:0]  ics_cur = {16'h0, edge_r, cie_r, cflag_r};
	wire [31:0]  ics_m   = merge(ics_cur, wdat_r, wm);
	wire [31:0]  zero_wr = ~wdat_r & wm;
	wire [31:0]  one_wr  = wdat_r & wm;
	wire         cnt_clr = wr_tcs & one_wr[frt_pkg::TCS_CLRB];

	// ----------------------------------------------------------------
	// prescaler and counter
	// ----------------------------------------------------------------
	wire [6:0]   pmask  = 7'((8'h01 << sel_r) - 8'h01);
	wire         tick   = (presc_r & pmask) == pmask;
	wire         hit    = cnt_r == clr_val_r;
	wire         clrm   = tick & mode_r & hit;
	wire         ovf    = tick & ~clrm & (cnt_r == 16'hffff);
	wire         cnt_mv = tick | cnt_clr | wr_cnt;
	wire [15:0]  cnt_nxt = cnt_clr ? frt_pkg::CNT_RST :
		wr_cnt ? cnt_m[15:0] :
		clrm ? frt_pkg::CNT_RST :
		tick ? 16'(cnt_r + 16'h0001) : cnt_r;

	// ----------------------------------------------------------------
	// compare and capture events
	// ----------------------------------------------------------------
	logic [NCH-1:0] match;
	logic [NCH-1:0] cap;
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			// only fires once per counter value, not while it stands
			assign match[g] = upd_r & (ocp_r[g] == cnt_r);
			wire rise = sync2_r[g] & ~sync3_r[g];
			wire fall = ~sync2_r[g] & sync3_r[g];
			assign cap[g] = (edge_r[2*g] & rise) |
				(edge_r[2*g+1] & fall);
		end
	endgenerate

	// pair mode routes the odd channel onto the even pin
	wire [NCH-1:0] tgl = {match[3] & ~pair_r[1],
		match[2] | (pair_r[1] & match[3]),
		match[1] & ~pair_r[0],
		match[0] | (pair_r[0] & match[1])};
	wire [NCH-1:0] lvl_b = wr_ocs ? ocs_m[frt_pkg::OCS_LVL +: NCH]
		: lvl_r;
	wire [NCH-1:0] lvl_nxt = lvl_b ^ tgl;

	wire [NCH-1:0] mflag_nxt = (mflag_r &
		~(wr_ocs ? zero_wr[frt_pkg::OCS_FLAG +: NCH] : 4'h0)) |
		match;
	wire [NCH-1:0] cflag_nxt = (cflag_r &
		~(wr_ics ? zero_wr[frt_pkg::ICS_FLAG +: NCH] : 4'h0)) |
		cap;

	wire [IST_W_L-1:0] ev = {cap & cie_r, match & mie_r,
		clrm & cmie_r, ovf};
	wire [IST_W_L-1:0] ist_nxt = (ist_r &
		~(wr_ist ? one_wr[IST_W_L-1:0] : 10'h000)) | ev;
	wire [31:0]  imk_m   = merge({22'h0, imk_r}, wdat_r, wm);
	wire [31:0]  clr_m   = merge({16'h0, clr_val_r}, wdat_r, wm);
	wire [IST_W_L-1:0] imk_nxt = wr_imk ? imk_m[IST_W_L-1:0] : imk_r;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	wire [5:0]   aridx = s_axi_araddr_i[7:2];
	wire [5:0]   oidx  = 6'(aridx - frt_pkg::IDX_OCP0);
	wire [5:0]   iidx  = 6'(aridx - frt_pkg::IDX_CAP0);
	wire         is_o  = aridx >= frt_pkg::IDX_OCP0 &&
		aridx < frt_pkg::IDX_CAP0;
	wire         is_i  = aridx >= frt_pkg::IDX_CAP0 && mapped(aridx);
	wire [31:0]  rd_val =
		(aridx == frt_pkg::IDX_CNT) ? {16'h0, cnt_r} :
		(aridx == frt_pkg::IDX_CLR) ? {16'h0, clr_val_r} :
		(aridx == frt_pkg::IDX_TCS) ? tcs_cur :
		(aridx == frt_pkg::IDX_OCS) ? ocs_cur :
		(aridx == frt_pkg::IDX_ICS) ? ics_cur :
		(aridx == frt_pkg::IDX_IST) ? {22'h0, ist_r} :
		(aridx == frt_pkg::IDX_IMK) ? {22'h0, imk_r} :
		is_o ? {16'h0, ocp_r[oidx[1:0]]} :
		is_i ? {16'h0, icp_r[iidx[1:0]]} : frt_pkg::REG_RST;

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			awrdy_r  <= 1'b0;
			wrdy_r   <= 1'b0;
			arrdy_r  <= 1'b0;
			awfull_r <= 1'b0;
			wfull_r  <= 1'b0;
			awidx_r  <= 6'h00;
			wdat_r   <= frt_pkg::REG_RST;
			wstb_r   <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r  <= frt_pkg::RESP_OK;
			rvalid_r <= 1'b0;
			rresp_r  <= frt_pkg::RESP_OK;
			rdata_r  <= frt_pkg::REG_RST;
		end else begin
			// one-cycle ready pulses keep ready itself registered
			awrdy_r <= s_axi_awvalid_i & ~awrdy_r & ~awfull_r;
			wrdy_r  <= s_axi_wvalid_i & ~wrdy_r & ~wfull_r;
			arrdy_r <= s_axi_arvalid_i & ~arrdy_r & ~rvalid_r;
			if (aw_take) begin
				awfull_r <= 1'b1;
				awidx_r  <= s_axi_awaddr_i[7:2];
			end else if (do_wr) begin
				awfull_r <= 1'b0;
			end
			if (w_take) begin
				wfull_r <= 1'b1;
				wdat_r  <= s_axi_wdata_i;
				wstb_r  <= s_axi_wstrb_i;
			end else if (do_wr) begin
				wfull_r <= 1'b0;
			end
			if (do_wr) begin
				bvalid_r <= 1'b1;
				bresp_r  <= mapped(awidx_r) ? frt_pkg::RESP_OK
					: frt_pkg::RESP_ERR;
			end else if (s_axi_bready_i) begin
				bvalid_r <= 1'b0;
			end
			if (s_axi_arvalid_i & arrdy_r) begin
				rvalid_r <= 1'b1;
				rdata_r  <= rd_val;
				rresp_r  <= mapped(aridx) ? frt_pkg::RESP_OK
					: frt_pkg::RESP_ERR;
			end else if (s_axi_rready_i) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// timer registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			cnt_r     <= frt_pkg::CNT_RST;
			clr_val_r <= frt_pkg::CLR_RST;
			presc_r   <= 7'h00;
			sel_r     <= 3'h0;
			mode_r    <= 1'b0;
			cmie_r    <= 1'b0;
			upd_r     <= 1'b0;
			mflag_r   <= 4'h0;
			mie_r     <= 4'h0;
			lvl_r     <= 4'h0;
			pair_r    <= 2'h0;
			cflag_r   <= 4'h0;
			cie_r     <= 4'h0;
			edge_r    <= 8'h00;
			ist_r     <= 10'h000;
			imk_r     <= 10'h000;
			irq_r     <= 1'b0;
		end else begin
			cnt_r   <= cnt_nxt;
			upd_r   <= cnt_mv;
			// restart the prescaler with the counter so ticks stay aligned
			presc_r <= (cnt_clr | wr_cnt) ? 7'h00 : 7'(presc_r + 7'h01);
			if (wr_clr)
				clr_val_r <= clr_m[15:0];
			if (wr_tcs) begin
				sel_r  <= tcs_m[frt_pkg::TCS_SEL +: 3];
				mode_r <= tcs_m[frt_pkg::TCS_MODE];
				cmie_r <= tcs_m[frt_pkg::TCS_CMIE];
			end
			if (wr_ocs) begin
				mie_r  <= ocs_m[frt_pkg::OCS_IE +: NCH];
				pair_r <= ocs_m[frt_pkg::OCS_PAIR +: 2];
			end
			if (wr_ics) begin
				cie_r  <= ics_m[frt_pkg::ICS_IE +: NCH];
				edge_r <= ics_m[frt_pkg::ICS_EDGE +: 2*NCH];
			end
			mflag_r <= mflag_nxt;
			cflag_r <= cflag_nxt;
			lvl_r   <= lvl_nxt;
			ist_r   <= ist_nxt;
			imk_r   <= imk_nxt;
			irq_r   <= |(ist_nxt & imk_nxt);
		end
	end

	// ----------------------------------------------------------------
	// per-channel storage and input synchronisers
	// ----------------------------------------------------------------
	generate
		for (g = 0; g < NCH; g++) begin : g_st
			wire wr_o = wr_ok &
				(awidx_r == 6'(frt_pkg::IDX_OCP0 + 6'(g)));
			wire [31:0] ocp_m = merge({16'h0, ocp_r[g]}, wdat_r, wm);
			always_ff @(posedge clock_i) begin
				if (!reset_n_i) begin
					ocp_r[g]   <= frt_pkg::OCP_RST;
					icp_r[g]   <= frt_pkg::CNT_RST;
					sync1_r[g] <= 1'b0;
					sync2_r[g] <= 1'b0;
					sync3_r[g] <= 1'b0;
				end else begin
					if (wr_o)
						ocp_r[g] <= ocp_m[15:0];
					if (cap[g])
						icp_r[g] <= cnt_r;
					sync1_r[g] <= capture_input_pins_i[g];
					sync2_r[g] <= sync1_r[g];
					sync3_r[g] <= sync2_r[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready_o = awrdy_r;
	assign s_axi_wready_o  = wrdy_r;
	assign s_axi_bresp_o   = bresp_r;
	assign s_axi_bvalid_o  = bvalid_r;
	assign s_axi_arready_o = arrdy_r;
	assign s_axi_rdata_o   = rdata_r;
	assign s_axi_rresp_o   = rresp_r;
	assign s_axi_rvalid_o  = rvalid_r;
	assign compare_out_o   = lvl_r;
	assign irq_o           = irq_r;

endmodule

// *** test/frt_pins_model.sv ***
`timescale 1ns/1ps
// --------------------
// capture pin sources
// --------------------
module frt_pins_model (
	input  wire logic       clock_i,
	input  wire logic [3:0] level_i,
	output logic      [3:0] capture_input_pins_o
);
	initial capture_input_pins_o = 4'h0;
	// pins move on the clock edge through a nonblocking update, so no race with the sampler
	always @(posedge clock_i) capture_input_pins_o <= level_i;
endmodule

// *** test/frt_properties.sv ***
`timescale 1ns/1ps
// --------------------
// port checks
// --------------------
module frt_properties #(
	parameter int NCH = 4
) (
	input wire logic           clock_i,
	input wire logic           reset_n_i,
	input wire logic           s_axi_awvalid_i,
	input wire logic           s_axi_awready_o,
	input wire logic           s_axi_wvalid_i,
	input wire logic           s_axi_wready_o,
	input wire logic [1:0]     s_axi_bresp_o,
	input wire logic           s_axi_bvalid_o,
	input wire logic           s_axi_bready_i,
	input wire logic           s_axi_arvalid_i,
	input wire logic           s_axi_arready_o,
	input wire logic [31:0]    s_axi_rdata_o,
	input wire logic           s_axi_rvalid_o,
	input wire logic           s_axi_rready_i,
	input wire logic [NCH-1:0] compare_out_o,
	input wire logic           irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	property p_rst_quiet;
		disable iff (1'b0) !reset_n_i |=> compare_out_o == '0 && !irq_o;
	endproperty
	property p_wr_answer;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
			|-> ##2 s_axi_bvalid_o;
	endproperty
	property p_rd_answer;
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
	endproperty
	property p_b_hold;
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	property p_r_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	property p_aw_pulse;
		s_axi_awready_o |=> !s_axi_awready_o;
	endproperty
	property p_ar_blocked;
		s_axi_rvalid_o |-> !s_axi_arready_o;
	endproperty
	// status only drops through a bus write, so a fall needs a write answer
	property p_irq_sticky;
		$fell(irq_o) |-> s_axi_bvalid_o;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("outputs active in reset");
	a_wr_answer: assert property (p_wr_answer)
		else $error("write answer late");
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer late");
	a_b_hold: assert property (p_b_hold)
		else $error("write answer dropped");
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped");
	a_aw_pulse: assert property (p_aw_pulse)
		else $error("address ready too long");
	a_ar_blocked: assert property (p_ar_blocked)
		else $error("read taken while busy");
	a_irq_sticky: assert property (p_irq_sticky)
		else $error("interrupt fell without write");
	c_irq: cover property ($rose(irq_o));
	c_err: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
	c_pin: cover property ($changed(compare_out_o));
endmodule
bind frt_timer frt_properties #(.NCH(NCH)) u_frt_properties (
	.clock_i        (clock_i),
	.reset_n_i      (reset_n_i),
	.s_axi_awvalid_i(s_axi_awvalid_i),
	.s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i (s_axi_wvalid_i),
	.s_axi_wready_o (s_axi_wready_o),
	.s_axi_bresp_o  (s_axi_bresp_o),
	.s_axi_bvalid_o (s_axi_bvalid_o),
	.s_axi_bready_i (s_axi_bready_i),
	.s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o),
	.s_axi_rdata_o  (s_axi_rdata_o),
	.s_axi_rvalid_o (s_axi_rvalid_o),
	.s_axi_rready_i (s_axi_rready_i),
	.compare_out_o  (compare_out_o),
	.irq_o          (irq_o)
);

// *** test/frt_timer_tb_top.sv ***
`timescale 1ns/1ps
module frt_timer_tb_top;
	localparam logic [7:0] A_CNT = {frt_pkg::IDX_CNT, 2'h0};
	localparam logic [7:0] A_CLR = {frt_pkg::IDX_CLR, 2'h0};
	localparam logic [7:0] A_TCS = {frt_pkg::IDX_TCS, 2'h0};
	localparam logic [7:0] A_OCS = {frt_pkg::IDX_OCS, 2'h0};
	localparam logic [7:0] A_ICS = {frt_pkg::IDX_ICS, 2'h0};
	localparam logic [7:0] A_IST = {frt_pkg::IDX_IST, 2'h0};
	localparam logic [7:0] A_IMK = {frt_pkg::IDX_IMK, 2'h0};
	localparam logic [7:0] A_OCP = {frt_pkg::IDX_OCP0, 2'h0};
	localparam logic [7:0] A_ICP = {frt_pkg::IDX_CAP0, 2'h0};
	logic        clock_i, reset_n_i, awv, wv, br, arv, rr, awr, wrd, bv;
	logic        arr, rv, irq;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rdat, v, v0;
	logic [15:0] dv;
	logic [1:0]  brs, rrs;
	logic [3:0]  lvl, pins, cmp;
	int          n_fail, compares, cyc, ts, t0, e;
	frt_timer #(.NCH(4)) DUT (
		.clock_i(clock_i), .reset_n_i(reset_n_i),
		.s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wrd), .s_axi_bresp_o(brs), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rrs),
		.s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
		.capture_input_pins_i(pins), .compare_out_o(cmp), .irq_o(irq)
	);
	frt_pins_model u_pins (
		.clock_i(clock_i), .level_i(lvl), .capture_input_pins_o(pins)
	);
	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) cyc <= cyc + 1;
	// --------------------
	// bus tasks
	// --------------------
	task automatic finish_test;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// ready raised late on purpose so the slave must hold its answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er = frt_pkg::RESP_OK);
		int n;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock_i);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
			if (bv && br) break;
			if (bv) br <= 1'b1;
		end
		br <= 1'b0;
		chk(brs, er);
		if (n == 50) begin
			n_fail++;
			finish_test();
		end
		@(posedge clock_i);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		ara <= a;
		arv <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock_i);
			if (arr) arv <= 1'b0;
			if (rv && rr) break;
			if (rv) rr <= 1'b1;
		end
		rr <= 1'b0;
		v = rdat;
		ts = cyc;
		if (n == 50) begin
			n_fail++;
			finish_test();
		end
		@(posedge clock_i);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] x,
			input logic [31:0] m = 32'hffff_ffff,
			input logic [1:0] er = frt_pkg::RESP_OK);
		rd(a);
		chk(v & m, x);
		chk(rrs, er);
	endtask
	task automatic wirq(input logic x);
		int n;
		for (n = 0; n < 200 && irq !== x; n++)
			@(posedge clock_i);
		chk(irq, x);
		if (irq !== x) finish_test();
	endtask
	// --------------------
	// sequence
	// --------------------
	initial begin
		{reset_n_i, awv, wv, br, arv, rr, n_fail, compares} = '0;
		{awa, ara, wd, lvl} = '0;
		repeat (16) @(posedge clock_i);
		reset_n_i <= 1'b1;
		@(posedge clock_i);
		rc(A_CLR, 32'h0000_ffff);
		rc(A_TCS, 32'h0);
		rc(A_ICS, 32'h0);
		rc(8'h1c, 32'h0, 32'hffff_ffff, frt_pkg::RESP_ERR);
		wr(A_ICP, 32'h0000_1234);
		rc(A_ICP, 32'h0);
		wr(A_TCS, 32'h7);
		wr(A_CNT, 32'h1234);
		rc(A_CNT, 32'h1234);
		wr(A_CNT, 32'h0);
		rc(A_CNT, 32'h0);
		wr(A_CNT, 32'h55);
		wr(A_TCS, 32'h17);
		rd(A_CNT);
		chk(32'(v[15:0] < 16'h0002), 32'h1);
		rc(A_TCS, 32'h7);
		for (int s = 0; s < 8; s++) begin
			wr(A_TCS, 32'(s));
			rd(A_CNT);
			v0 = v;
			t0 = ts;
			repeat (1000) @(posedge clock_i);
			rd(A_CNT);
			e = ts - t0;
			dv = v[15:0] - v0[15:0];
			chk(32'(dv == 16'(e >> s) || dv == 16'((e >> s) + 1)), 1);
		end
		wr(A_TCS, 32'h0);
		wr(A_IST, 32'h3ff);
		wr(A_IMK, 32'h1);
		wr(A_CNT, 32'hfff0);
		wirq(1'b1);
		rc(A_IST, 32'h1, 32'h1);
		wr(A_IST, 32'h1);
		wirq(1'b0);
		wr(A_IMK, 32'h0);
		wr(A_CNT, 32'hfff0);
		repeat (40) @(posedge clock_i);
		chk(irq, 1'b0);
		rc(A_IST, 32'h1, 32'h1);
		wr(A_IST, 32'h3ff);
		wr(A_CLR, 32'h40);
		wr(A_TCS, 32'h28);
		wr(A_CNT, 32'h0);
		repeat (200) @(posedge clock_i);
		rd(A_CNT);
		chk(32'(v[15:0] <= 16'h0040), 32'h1);
		rc(A_IST, 32'h2, 32'h3);
		wr(A_TCS, 32'h08);
		wr(A_IST, 32'h3);
		repeat (200) @(posedge clock_i);
		rc(A_IST, 32'h0, 32'h2);
		wr(A_TCS, 32'h7);
		wr(A_CNT, 32'hff00);
		for (int i = 0; i < 4; i++)
			wr(A_OCP + 8'(4 * i), 32'(16 * (i + 1)));
		wr(A_OCS, 32'h0530);
		wr(A_IST, 32'h3ff);
		chk(cmp, 4'h5);
		wr(A_TCS, 32'h0);
		wr(A_CNT, 32'h0);
		repeat (96) @(posedge clock_i);
		chk(cmp, 4'ha);
		rc(A_OCS, 32'hf, 32'hf);
		rc(A_IST, 32'h0c, 32'h3c);
		wr(A_OCS, 32'h0030);
		rc(A_OCS, 32'h0, 32'hf);
		wr(A_OCS, 32'h1000);
		wr(A_CNT, 32'h0);
		repeat (24) @(posedge clock_i);
		chk(cmp, 4'h1);
		repeat (72) @(posedge clock_i);
		chk(cmp, 4'hc);
		wr(A_TCS, 32'h7);
		wr(A_ICS, 32'h3910);
		wr(A_IMK, 32'h3c0);
		wr(A_IST, 32'h3ff);
		wr(A_CNT, 32'h777);
		lvl <= 4'hf;
		repeat (8) @(posedge clock_i);
		rc(A_ICS, 32'h5, 32'hf);
		rc(A_ICP, 32'h777);
		rc(A_ICP + 8'h8, 32'h777);
		rc(A_IST, 32'h40);
		chk(irq, 1'b1);
		wr(A_ICS, 32'h3910);
		wr(A_CNT, 32'h888);
		lvl <= 4'h0;
		repeat (8) @(posedge clock_i);
		rc(A_ICS, 32'h6, 32'hf);
		rc(A_ICP + 8'h4, 32'h888);
		rc(A_ICP, 32'h777);
		finish_test();
	end
endmodule
